// *** mtl_cfg.svh ***
`ifndef MTL_CFG_SVH
`define MTL_CFG_SVH

// =====================================================================
// register map
`define MTL_OFF_CTRL     12'h000
`define MTL_OFF_DELAY    12'h004
`define MTL_OFF_HOLD     12'h008
`define MTL_OFF_STATUS   12'h00C

// =====================================================================
// control fields
`define MTL_CTRL_FN_LSB  0
`define MTL_CTRL_FN_MSB  6
`define MTL_CTRL_POL     8
`define MTL_CTRL_RNG_LSB 9
`define MTL_CTRL_RNG_MSB 10
`define MTL_CTRL_INV     11

// =====================================================================
// status fields
`define MTL_STAT_OUT     0
`define MTL_STAT_ACT     1
`define MTL_STAT_INH     2
`define MTL_STAT_PH_LSB  4
`define MTL_STAT_PH_MSB  6
`define MTL_STAT_CNT_LSB 8
`define MTL_STAT_CNT_MSB 15

// =====================================================================
// reset values and time setting limits (units of the range step)
`define MTL_FN_RESET     7'h41
`define MTL_TIME_RESET   8'h0A
`define MTL_TIME_MIN     8'h0A
`define MTL_TIME_MAX     8'h96

// =====================================================================
// function select codes, bit n-1 is selector switch n
`define MTL_FN_FOLLOW    7'h41
`define MTL_FN_ONDLY     7'h53
`define MTL_FN_OFFDLY    7'h55
`define MTL_FN_ONOFF     7'h51
`define MTL_FN_ONESHOT   7'h50
`define MTL_FN_DLYSHOT   7'h18
`define MTL_FN_LIMIT     7'h43
`define MTL_FN_REPEAT    7'h59
`define MTL_FN_EDGELATCH 7'h76
`define MTL_FN_LVLLATCH  7'h77
`define MTL_FN_DLYLATCH  7'h73
`define MTL_FN_LIMLATCH  7'h63

// =====================================================================
// range codes and timebase
`define MTL_RNG_LOW      2'h0
`define MTL_RNG_MID      2'h1
`define MTL_CLK_HZ       25000000
`define MTL_STEP_US      1000
`define MTL_STEP_CYCLES  (`MTL_CLK_HZ / 1000000 * `MTL_STEP_US)
`define MTL_DECADE_LAST  4'h9
`define MTL_CENTURY_LAST 7'h63

`endif

// *** mtl_pkg.sv ***
package mtl_pkg;

  // ===================================================================
  // timing functions
  typedef enum logic [3:0] {
    MD_FOLLOW, MD_ONDLY, MD_OFFDLY, MD_ONOFF, MD_ONESHOT, MD_DLYSHOT,
    MD_LIMIT, MD_REPEAT, MD_EDGELATCH, MD_LVLLATCH, MD_DLYLATCH,
    MD_LIMLATCH, MD_NONE
  } mtl_mode_type;

  // ===================================================================
  // sequence phases
  typedef enum logic [2:0] {PH_IDLE, PH_DELAY, PH_ON, PH_HOLD, PH_LOCK} mtl_phase_type;

  // ===================================================================
  // module states
  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
  } mtl_sync_state_type;

  typedef struct packed {
    logic [15:0] stepCnt;
    logic [3:0]  decCnt;
    logic [6:0]  centCnt;
    logic        tick;
  } mtl_tick_state_type;

  typedef struct packed {
    logic [6:0]    fnSel;
    logic          outPol;
    logic [1:0]    range;
    logic          inInvert;
    logic [7:0]    delaySet;
    logic [7:0]    holdSet;
    mtl_phase_type phase;
    logic [7:0]    cnt;
    logic          actPrev;
    logic [6:0]    fnPrev;
    logic          outLogic;
    logic          switchOut;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
  } mtl_state_type;

endpackage

// *** mtl_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module mtl_sync
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // raw pins
  input  wire logic sensorIn,
  input  wire logic inhibitN,
  // synchronised levels
  output var  logic sensorSync,
  output var  logic inhibitNSync
);

  mtl_pkg::mtl_sync_state_type s;
  mtl_pkg::mtl_sync_state_type n;

  always_comb
  begin
    n        = s;
    n.stage1 = {sensorIn, inhibitN};
    n.stage2 = s.stage1;
  end

  // idle high on both pins: no input, no inhibit
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s.stage1 <= 2'h3;
      s.stage2 <= 2'h3;
    end
    else
    begin
      s <= n;
    end
  end

  assign sensorSync   = s.stage2[1];
  assign inhibitNSync = s.stage2[0];

endmodule

`default_nettype wire

// *** mtl_tick.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mtl_cfg.svh"

module mtl_tick
#(
  parameter int STEP_CYCLES = `MTL_STEP_CYCLES
)
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // range select
  input  wire logic [1:0] range,
  // one-cycle timebase pulse
  output var  logic       tick
);

  mtl_pkg::mtl_tick_state_type s;
  mtl_pkg::mtl_tick_state_type n;
  logic                        stepEnd;

  always_comb
  begin
    n       = s;
    stepEnd = (s.stepCnt == 16'(STEP_CYCLES - 1));
    n.stepCnt = stepEnd ? 16'h0000 : s.stepCnt + 16'h0001;
    if (stepEnd)
    begin
      n.decCnt  = (s.decCnt == `MTL_DECADE_LAST) ? 4'h0 : s.decCnt + 4'h1;
      n.centCnt = (s.centCnt == `MTL_CENTURY_LAST) ? 7'h00 : s.centCnt + 7'h01;
    end
    // step scaled by 1, 10 or 100 for the three ranges
    case (range)
      `MTL_RNG_LOW: n.tick = stepEnd;
      `MTL_RNG_MID: n.tick = stepEnd && (s.decCnt == `MTL_DECADE_LAST);
      default:      n.tick = stepEnd && (s.centCnt == `MTL_CENTURY_LAST);
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign tick = s.tick;

endmodule

`default_nettype wire

// *** mtl_timing_logic.sv ***
// How it works
// R1 - follow mode: output copies the qualified input directly.
// R2 - follow mode: inhibit forces the output off while asserted.
// R3 - on-delay: output on after input held for delay; a gap restarts timing.
// R4 - on-delay: inhibit drops output and clears timer; release re-times.
// R5 - off-delay: output on at once; off after input absent for hold.
// R6 - off-delay: inhibit blocks new output; running output finishes hold.
// R7 - on-and-off delay: delay qualifies, hold releases, separate settings.
// R8 - on-and-off delay: inhibit clears delay; running output finishes hold.
// R9 - one-shot: input onset gives one pulse of hold length.
// R10 - one-shot: inhibit blocks triggering, never cuts a running pulse.
// R11 - delayed one-shot: onset starts delay, then hold pulse; re-arm needs new onset.
// R12 - delayed one-shot: inhibit in delay aborts; pulse unaffected.
// R13 - limit: output follows input until hold expires; removal clears timer.
// R14 - limit: inhibit turns output off; release with input restarts timer.
// R15 - repeat cycle: delay then hold pulse, repeating while input stays.
// R16 - repeat cycle: removal lets a running pulse end, then waits.
// R17 - repeat cycle: inhibit stops cycling, pulse ends; release starts delay.
// R18 - edge latch: onset latches on; inhibit clears; relatch needs new onset.
// R19 - level latch: input latches on; inhibit forces off; relatches after.
// R20 - delay latch: latch on after continuous delay; removal clears timer.
// R21 - delay latch: inhibit clears latch and timing, blocks output meanwhile.
// R22 - limit latch: like limit but stays off until inhibit pulse resets.
// R23 - seven-bit function code selects one of twelve functions.
// R24 - polarity bit inverts final output for normally closed use.
// R25 - two-bit range sets a shared timebase for delay and hold.
// R26 - invert bit makes high-going input the active level.
// R27 - pins are synchronised; timers count range-scaled ticks.
// R28 - reset clears timers and latches, output inactive.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mtl_cfg.svh"

module mtl_timing_logic
#(
  parameter int STEP_CYCLES = `MTL_STEP_CYCLES
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // sensor side pins
  input  wire logic        sensorIn,
  input  wire logic        inhibitN,
  // output switch
  output var  logic        switchOut
);

  mtl_pkg::mtl_state_type s;
  mtl_pkg::mtl_state_type n;
  logic                   sensorSync;
  logic                   inhibitNSync;
  logic                   tick;
  logic                   act;
  logic                   inh;
  logic                   rise;
  logic                   dlyDone;
  logic                   hldDone;
  logic                   cntEn;
  logic                   fnStable;
  mtl_pkg::mtl_mode_type  mode;

  // ===================================================================
  // helpers
  function automatic mtl_pkg::mtl_mode_type fnDecode(input logic [6:0] code);
    case (code)
      `MTL_FN_FOLLOW:    fnDecode = mtl_pkg::MD_FOLLOW;
      `MTL_FN_ONDLY:     fnDecode = mtl_pkg::MD_ONDLY;
      `MTL_FN_OFFDLY:    fnDecode = mtl_pkg::MD_OFFDLY;
      `MTL_FN_ONOFF:     fnDecode = mtl_pkg::MD_ONOFF;
      `MTL_FN_ONESHOT:   fnDecode = mtl_pkg::MD_ONESHOT;
      `MTL_FN_DLYSHOT:   fnDecode = mtl_pkg::MD_DLYSHOT;
      `MTL_FN_LIMIT:     fnDecode = mtl_pkg::MD_LIMIT;
      `MTL_FN_REPEAT:    fnDecode = mtl_pkg::MD_REPEAT;
      `MTL_FN_EDGELATCH: fnDecode = mtl_pkg::MD_EDGELATCH;
      `MTL_FN_LVLLATCH:  fnDecode = mtl_pkg::MD_LVLLATCH;
      `MTL_FN_DLYLATCH:  fnDecode = mtl_pkg::MD_DLYLATCH;
      `MTL_FN_LIMLATCH:  fnDecode = mtl_pkg::MD_LIMLATCH;
      default:           fnDecode = mtl_pkg::MD_NONE;
    endcase
  endfunction

  // settings kept inside the documented span of the range
  function automatic logic timerDone(input logic tk, input logic [7:0] cnt, input logic [7:0] set);
    logic [7:0] lim;
    lim = (set < `MTL_TIME_MIN) ? `MTL_TIME_MIN : (set > `MTL_TIME_MAX) ? `MTL_TIME_MAX : set;
    timerDone = tk && (({1'b0, cnt} + 9'h001) >= {1'b0, lim});
  endfunction

  function automatic logic addrKnown(input logic [11:0] a);
    addrKnown = (a == `MTL_OFF_CTRL) || (a == `MTL_OFF_DELAY) ||
                (a == `MTL_OFF_HOLD) || (a == `MTL_OFF_STATUS);
  endfunction

  // ===================================================================
  // input conditioning and timebase
  mtl_sync u_sync
  (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .sensorIn     (sensorIn),
    .inhibitN     (inhibitN),
    .sensorSync   (sensorSync),
    .inhibitNSync (inhibitNSync)
  );

  mtl_tick #(.STEP_CYCLES(STEP_CYCLES)) u_tick
  (
    .sys_clk (sys_clk),
    .reset   (reset),
    .range   (s.range),
    .tick    (tick)
  );

  assign act      = s.inInvert ? sensorSync : ~sensorSync;  // see R26
  assign inh      = ~inhibitNSync;                          // see R27
  assign rise     = act & ~s.actPrev;
  assign mode     = fnDecode(s.fnSel);                      // see R23
  assign fnStable = (s.fnSel == s.fnPrev);
  assign dlyDone  = timerDone(tick, s.cnt, s.delaySet);     // see R25
  assign hldDone  = timerDone(tick, s.cnt, s.holdSet);

  // ===================================================================
  // sequencer and register file
  always_comb
  begin
    n         = s;
    n.actPrev = act;
    n.fnPrev  = s.fnSel;
    cntEn     = tick && (s.phase != mtl_pkg::PH_IDLE) && (s.phase != mtl_pkg::PH_LOCK) &&
                !((mode == mtl_pkg::MD_LIMLATCH) && !act);
    if (cntEn && (s.cnt != 8'hFF))
    begin
      n.cnt = s.cnt + 8'h01;                                // see R27
    end
    case (mode)
      mtl_pkg::MD_ONDLY, mtl_pkg::MD_DLYLATCH:
      begin
        case (s.phase)
          mtl_pkg::PH_IDLE:  if (act && !inh) n.phase = mtl_pkg::PH_DELAY;
          mtl_pkg::PH_DELAY:
          begin
            if (!act || inh) n.phase = mtl_pkg::PH_IDLE;    // see R3 R4 R20 R21
            else if (dlyDone) n.phase = mtl_pkg::PH_ON;     // see R3 R20
          end
          mtl_pkg::PH_ON:
          begin
            if (inh) n.phase = mtl_pkg::PH_IDLE;            // see R4 R21
            else if (!act && (mode == mtl_pkg::MD_ONDLY)) n.phase = mtl_pkg::PH_IDLE;
          end
          default:           n.phase = mtl_pkg::PH_IDLE;
        endcase
      end
      mtl_pkg::MD_OFFDLY, mtl_pkg::MD_ONOFF:
      begin
        case (s.phase)
          mtl_pkg::PH_IDLE:
          begin
            if (act && !inh)                                // see R6
              n.phase = (mode == mtl_pkg::MD_OFFDLY) ? mtl_pkg::PH_ON : mtl_pkg::PH_DELAY;  // see R5 R7
          end
          mtl_pkg::PH_DELAY:
          begin
            if (!act || inh) n.phase = mtl_pkg::PH_IDLE;    // see R8
            else if (dlyDone) n.phase = mtl_pkg::PH_ON;     // see R7
          end
          mtl_pkg::PH_ON:    if (!act || inh) n.phase = mtl_pkg::PH_HOLD;  // see R6 R8
          mtl_pkg::PH_HOLD:
          begin
            if (act && !inh) n.phase = mtl_pkg::PH_ON;
            else if (hldDone) n.phase = mtl_pkg::PH_IDLE;   // see R5 R7
          end
          default:           n.phase = mtl_pkg::PH_IDLE;
        endcase
      end
      mtl_pkg::MD_ONESHOT:
      begin
        case (s.phase)
          mtl_pkg::PH_IDLE:  if (rise && !inh) n.phase = mtl_pkg::PH_HOLD;  // see R9 R10
          mtl_pkg::PH_HOLD:  if (hldDone) n.phase = mtl_pkg::PH_IDLE;       // see R9 R10
          default:           n.phase = mtl_pkg::PH_IDLE;
        endcase
      end
      mtl_pkg::MD_DLYSHOT:
      begin
        case (s.phase)
          mtl_pkg::PH_IDLE:  if (rise && !inh) n.phase = mtl_pkg::PH_DELAY; // see R11
          mtl_pkg::PH_DELAY:
          begin
            if (inh) n.phase = mtl_pkg::PH_IDLE;            // see R12
            else if (dlyDone) n.phase = mtl_pkg::PH_ON;     // see R11
          end
          mtl_pkg::PH_ON:    if (hldDone) n.phase = mtl_pkg::PH_IDLE;       // see R11 R12
          default:           n.phase = mtl_pkg::PH_IDLE;
        endcase
      end
      mtl_pkg::MD_LIMIT, mtl_pkg::MD_LIMLATCH:
      begin
        case (s.phase)
          mtl_pkg::PH_IDLE:  if (act && !inh) n.phase = mtl_pkg::PH_ON;     // see R13 R14
          mtl_pkg::PH_ON:
          begin
            if (inh) n.phase = mtl_pkg::PH_IDLE;            // see R14 R22
            else if (!act && (mode == mtl_pkg::MD_LIMIT)) n.phase = mtl_pkg::PH_IDLE;  // see R13
            else if (hldDone) n.phase = mtl_pkg::PH_LOCK;   // see R13 R22
          end
          mtl_pkg::PH_LOCK:
          begin
            if (inh) n.phase = mtl_pkg::PH_IDLE;            // see R22
            else if (!act && (mode == mtl_pkg::MD_LIMIT)) n.phase = mtl_pkg::PH_IDLE;
          end
          default:           n.phase = mtl_pkg::PH_IDLE;
        endcase
      end
      mtl_pkg::MD_REPEAT:
      begin
        case (s.phase)
          mtl_pkg::PH_IDLE:  if (act && !inh) n.phase = mtl_pkg::PH_DELAY;  // see R15 R17
          mtl_pkg::PH_DELAY:
          begin
            if (!act || inh) n.phase = mtl_pkg::PH_IDLE;    // see R16 R17
            else if (dlyDone) n.phase = mtl_pkg::PH_ON;     // see R15
          end
          mtl_pkg::PH_ON:                                   // see R16 R17
          begin
            if (hldDone) n.phase = (act && !inh) ? mtl_pkg::PH_DELAY : mtl_pkg::PH_IDLE;  // see R15
          end
          default:           n.phase = mtl_pkg::PH_IDLE;
        endcase
      end
      mtl_pkg::MD_EDGELATCH, mtl_pkg::MD_LVLLATCH:
      begin
        case (s.phase)
          mtl_pkg::PH_IDLE:
          begin
            if (!inh && ((mode == mtl_pkg::MD_EDGELATCH) ? rise : act))  // see R18 R19
              n.phase = mtl_pkg::PH_ON;
          end
          mtl_pkg::PH_ON:    if (inh) n.phase = mtl_pkg::PH_IDLE;            // see R18 R19
          default:           n.phase = mtl_pkg::PH_IDLE;
        endcase
      end
      default:
      begin
        n.phase = mtl_pkg::PH_IDLE;
      end
    endcase
    // a change of function starts clean
    if (!fnStable)
    begin
      n.phase = mtl_pkg::PH_IDLE;
    end
    if (n.phase != s.phase)
    begin
      n.cnt = 8'h00;
    end
    case (mode)
      mtl_pkg::MD_FOLLOW:   n.outLogic = act && !inh;                        // see R1 R2
      mtl_pkg::MD_LIMLATCH: n.outLogic = (n.phase == mtl_pkg::PH_ON) && act && !inh;  // see R22
      mtl_pkg::MD_NONE:     n.outLogic = 1'b0;
      default:              n.outLogic = (n.phase == mtl_pkg::PH_ON) || (n.phase == mtl_pkg::PH_HOLD);
    endcase
    n.switchOut = n.outLogic ^ s.outPol;                                     // see R24
    // apb: one wait state, write lands on the pready edge
    n.pready  = psel && penable && !s.pready;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    if (psel && penable && !s.pready)
    begin
      n.pslverr = !addrKnown(paddr);
      case (paddr)
        `MTL_OFF_CTRL:
        begin
          n.prdata[`MTL_CTRL_FN_MSB:`MTL_CTRL_FN_LSB]   = s.fnSel;
          n.prdata[`MTL_CTRL_POL]                       = s.outPol;
          n.prdata[`MTL_CTRL_RNG_MSB:`MTL_CTRL_RNG_LSB] = s.range;
          n.prdata[`MTL_CTRL_INV]                       = s.inInvert;
        end
        `MTL_OFF_DELAY: n.prdata[7:0] = s.delaySet;
        `MTL_OFF_HOLD:  n.prdata[7:0] = s.holdSet;
        `MTL_OFF_STATUS:
        begin
          n.prdata[`MTL_STAT_OUT]                         = s.outLogic;
          n.prdata[`MTL_STAT_ACT]                         = act;
          n.prdata[`MTL_STAT_INH]                         = inh;
          n.prdata[`MTL_STAT_PH_MSB:`MTL_STAT_PH_LSB]     = s.phase;
          n.prdata[`MTL_STAT_CNT_MSB:`MTL_STAT_CNT_LSB]   = s.cnt;
        end
        default: n.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && s.pready && pwrite)
    begin
      case (paddr)
        `MTL_OFF_CTRL:
        begin
          n.fnSel    = pwdata[`MTL_CTRL_FN_MSB:`MTL_CTRL_FN_LSB];
          n.outPol   = pwdata[`MTL_CTRL_POL];
          n.range    = pwdata[`MTL_CTRL_RNG_MSB:`MTL_CTRL_RNG_LSB];
          n.inInvert = pwdata[`MTL_CTRL_INV];
        end
        `MTL_OFF_DELAY: n.delaySet = pwdata[7:0];
        `MTL_OFF_HOLD:  n.holdSet  = pwdata[7:0];
        default:        n.fnSel    = s.fnSel;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s          <= '0;                                     // see R28
      s.fnSel    <= `MTL_FN_RESET;
      s.fnPrev   <= `MTL_FN_RESET;
      s.delaySet <= `MTL_TIME_RESET;
      s.holdSet  <= `MTL_TIME_RESET;
      s.actPrev  <= 1'b1;
    end
    else
    begin
      s <= n;
    end
  end

  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign switchOut = s.switchOut;

  // ===================================================================
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  a_follow_track: assert property ((mode == mtl_pkg::MD_FOLLOW) && fnStable && !inh |=> s.outLogic == $past(act))  // see R1
    else $error("follow output does not copy input");
  a_follow_inhibit: assert property ((mode == mtl_pkg::MD_FOLLOW) && inh |=> !s.outLogic)  // see R2
    else $error("follow output on under inhibit");
  a_ondelay_wait: assert property ((mode == mtl_pkg::MD_ONDLY) && fnStable && (s.phase == mtl_pkg::PH_IDLE)
    |=> !s.outLogic)  // see R3
    else $error("on delay output without delay");
  a_ondelay_inhibit: assert property ((mode == mtl_pkg::MD_ONDLY) && inh |=> !s.outLogic && s.cnt == 8'h00)  // see R4
    else $error("on delay not cleared by inhibit");
  a_offdelay_fast: assert property ((mode == mtl_pkg::MD_OFFDLY) && fnStable && act && !inh |=> s.outLogic)  // see R5
    else $error("off delay output late");
  a_oneshot_block: assert property ((mode == mtl_pkg::MD_ONESHOT) && fnStable && (s.phase == mtl_pkg::PH_IDLE) && inh
    |=> !s.outLogic)  // see R10
    else $error("one shot fired under inhibit");
  a_limit_inhibit: assert property ((mode == mtl_pkg::MD_LIMIT) && inh |=> !s.outLogic ##1 !s.outLogic || !$past(inh))  // see R14
    else $error("limit output on under inhibit");
  a_level_latch: assert property ((mode == mtl_pkg::MD_LVLLATCH) && fnStable && act && !inh |=> s.outLogic)  // see R19
    else $error("level latch did not set");
  a_pin_polarity: assert property (s.switchOut == (s.outLogic ^ $past(s.outPol)))  // see R24
    else $error("output pin polarity wrong");
  a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

endmodule

`default_nettype wire

// *** mtl_sensor_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// sensor amplifier and inhibit switch
module mtl_sensor_model
(
  // clock
  input  wire logic sys_clk,
  // bench commands
  input  wire logic present,
  input  wire logic inhibit,
  input  wire logic actHigh,
  // pins
  output var  logic sensorIn,
  output var  logic inhibitN
);
  // sinking output pulls low on the condition; with actHigh set the sensorIn pin goes high on present instead
  always_ff @(posedge sys_clk)
  begin
    sensorIn <= actHigh ? present : !present;
    inhibitN <= !inhibit;
  end
endmodule

`default_nettype wire

// *** multi_mode_timing_logic_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mtl_cfg.svh"

module multi_mode_timing_logic_tb;
  // =====================================================================
  // signals
  logic        sys_clk  = 1'b0;
  logic        reset    = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sensorIn;
  logic        inhibitN;
  logic        switchOut;
  logic        present  = 1'b0;
  logic        inhibit  = 1'b0;
  logic        actHigh  = 1'b0;
  logic [31:0] rd;
  logic        err;
  int          fails    = 0;
  int          compares = 0;
  int          tickLen  = 4;
  // [11] inhibit instead of removal, [10:4] function, [3:0] output at 8, 60, 68, 120 cycles
  localparam logic [11:0] ROWS [23] = '{
    12'h41C, 12'h534, 12'h55E,
    12'h516, 12'h508, 12'h186,
    12'h438, 12'h596, 12'h76F,
    12'h77F, 12'h737, 12'h638,
    12'h000, 12'hD34, 12'hD5E,
    12'hD16, 12'h986, 12'hD96,
    12'hC38, 12'hF6C, 12'hF7C,
    12'hF34, 12'hE38
  };

  mtl_timing_logic #(.STEP_CYCLES(4)) uut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensorIn(sensorIn), .inhibitN(inhibitN), .switchOut(switchOut));

  mtl_sensor_model partner (.sys_clk(sys_clk), .present(present), .inhibit(inhibit), .actHigh(actHigh),
    .sensorIn(sensorIn), .inhibitN(inhibitN));

  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end

  // =====================================================================
  // tasks
  task automatic complete_run;
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic pins(input logic p, input logic i, input int n);
    present <= p;
    inhibit <= i;
    waitc(n);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic out_is(input logic e);
    check({31'h0, switchOut}, {31'h0, e});
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // =====================================================================
  // tests
  initial
  begin
    waitc(5);
    reset <= 1'b0;
    waitc(2);
    out_is(1'b0);
    apb(1'b0, `MTL_OFF_CTRL, 32'h0000_0000);
    check(rd, {25'h0, `MTL_FN_RESET});
    apb(1'b0, `MTL_OFF_HOLD, 32'h0000_0000);
    check(rd, 32'h0000_000A);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    pins(1'b1, 1'b1, 8);
    out_is(1'b0);
    pins(1'b1, 1'b0, 8);
    out_is(1'b1);
    apb(1'b1, `MTL_OFF_CTRL, 32'h0000_0141);
    waitc(4);
    out_is(1'b0);
    pins(1'b0, 1'b0, 8);
    out_is(1'b1);
    apb(1'b1, `MTL_OFF_CTRL, 32'h0000_0841);
    actHigh <= 1'b1;
    pins(1'b1, 1'b0, 8);
    out_is(1'b1);
    pins(1'b0, 1'b0, 8);
    out_is(1'b0);
    actHigh <= 1'b0;
    for (int k = 0; k < 23; k++)
    begin
      apb(1'b1, `MTL_OFF_CTRL, {25'h0, ROWS[k][10:4]});
      pins(1'b0, 1'b1, 8);
      pins(1'b0, 1'b0, 8);
      pins(1'b1, 1'b0, 8);
      out_is(ROWS[k][3]);
      waitc(52);
      out_is(ROWS[k][2]);
      pins(ROWS[k][11], ROWS[k][11], 8);
      out_is(ROWS[k][1]);
      waitc(52);
      out_is(ROWS[k][0]);
    end
    apb(1'b1, `MTL_OFF_DELAY, 32'h0000_0014);
    apb(1'b0, `MTL_OFF_DELAY, 32'h0000_0000);
    check(rd, 32'h0000_0014);
    for (int r = 0; r < 3; r++)
    begin
      apb(1'b1, `MTL_OFF_CTRL, {21'h0, 2'(r), 2'h0, `MTL_FN_ONDLY});
      pins(1'b0, 1'b0, 8);
      pins(1'b1, 1'b0, 19 * tickLen);
      out_is(1'b0);
      waitc(tickLen + 8);
      out_is(1'b1);
      tickLen = tickLen * 10;
    end
    complete_run();
  end

  // hang guard
  initial
  begin
    waitc(20000);
    fails++;
    complete_run();
  end
endmodule

`default_nettype wire
